// File: inc/frt_pkg.sv
// package: register map, fields and constants of the free-run timer block
package frt_pkg;
  // register byte offsets on apb
  localparam logic [7:0] ADDR_COUNT   = 8'h00; // free_run_count_value
  localparam logic [7:0] ADDR_CTRL    = 8'h04; // timer_control_status
  localparam logic [7:0] ADDR_EDGE    = 8'h08; // capture edge selects
  localparam logic [7:0] ADDR_STATUS  = 8'h0C; // sticky events, read clears
  localparam logic [7:0] ADDR_MASK    = 8'h10; // interrupt enables
  localparam logic [7:0] ADDR_CAP0    = 8'h14; // capture 0..3 at +4 each
  localparam logic [7:0] ADDR_VECTOR  = 8'h24; // interrupt vector number
  // control fields
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_DIV_LSB  = 1;
  localparam int DIV_SEL_W     = 2;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // status layout: bit 0 overflow, bits 4..1 captures
  localparam int STAT_OVF_BIT  = 0;
  localparam int STAT_CAP_LSB  = 1;
  localparam int EVENT_W       = 5;
  // prescaler ratios log2: 1, 2, 4, 8 machine clocks per tick
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_2 = 2'h1;
  localparam logic [1:0] DIV_4 = 2'h2;
  localparam logic [1:0] DIV_8 = 2'h3;
  localparam int PRESC_W = 3;
  // edge select codes per channel
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // interrupt vector of the counter overflow
  localparam logic [7:0] OVF_VECTOR = 8'h13;
endpackage

// File: core/frt_capture_chan.sv
// one input capture channel: edge detect and latch of the running count
`timescale 1ns/1ps
module frt_capture_chan #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             pin,
  input  wire logic [1:0]       edge_sel,
  input  wire logic [WIDTH-1:0] count,
  output logic [WIDTH-1:0]      captured,
  output logic                  hit
);
  logic pin_last;
  logic rise;
  logic fall;
  logic take;

  // previous pin level for edge detection
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      pin_last <= 1'b0;
    else
      pin_last <= pin;
  end

  // qualify edges by the selected polarity
  always_comb
  begin
    rise = pin & ~pin_last;
    fall = ~pin & pin_last;
    unique case (edge_sel)
      frt_pkg::EDGE_OFF:  take = 1'b0;
      frt_pkg::EDGE_RISE: take = rise;
      frt_pkg::EDGE_FALL: take = fall;
      frt_pkg::EDGE_BOTH: take = rise | fall;
    endcase
  end

  // value held until the next qualifying edge
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      captured <= '0;
    else if (take)
      captured <= count;
  end

  // one-cycle event toward the status register
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      hit <= 1'b0;
    else
      hit <= take;
  end
endmodule

// File: core/frt_timer.sv
// free-running 16-bit timer with prescaler, four captures and apb registers
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// How it works
// - the counter is sixteen bits and steps by one on each prescaled tick.
// - the tick divides the machine clock by one of four ratios from control.
// - reading the count register returns the live counter value.
// - a count write is accepted only while halted and counting resumes there.
// - a single counter channel raises an interrupt each time it overflows.
// - the overflow request is tagged with vector nineteen.
// - four capture channels store the live count on a qualifying pin edge.
// - each channel triggers on rising, falling or both edges.
// - a capture channel raises an interrupt request on its edge.
module frt_timer #(
  parameter int WIDTH    = 16,
  parameter int CHANNELS = 4
) (
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [CHANNELS-1:0] capture_pin,
  output logic                     irq,
  output logic                     ovf_irq,
  output logic      [7:0]          irq_vector
);
  // map and field layout are fixed; refuse other sizes early
  initial
  begin
    if (WIDTH != 16)
      $error("frt_timer supports WIDTH 16 only");
    if (CHANNELS != 4)
      $error("frt_timer supports CHANNELS 4 only");
    if (frt_pkg::EVENT_W != CHANNELS + 1)
      $error("frt_timer status needs one bit per channel plus one");
    if (frt_pkg::DIV_SEL_W != 2)
      $error("frt_timer divide select must be two bits");
  end

  ////////////////////////////////////////////////////////////////////////
  // register map, byte addresses, one aligned word each
  //   0x00 count    live counter, low sixteen bits, rest reads zero
  //   0x04 control  bit 0 run, bits 2:1 divide select
  //   0x08 edges    two bits per channel, channel i at bits 2i+1:2i
  //   0x0C status   bit 0 overflow, bits 4:1 captures, read clears
  //   0x10 mask     same layout as status, one enable per source
  //   0x14 capture 0, then channels 1..3 at four bytes apart
  //   0x24 vector   constant number of the overflow request
  //   anything else answers with an error and no side effect
  //
  // divide select
  //   0 tick on every clock
  //   1 tick on every second clock
  //   2 tick on every fourth clock
  //   3 tick on every eighth clock
  //   prescaler is cleared while halted, so a restart begins a full
  //   period; a divide change mid-run may shorten one period only
  //
  // edge select per channel
  //   0 channel off, pin ignored
  //   1 rising edges only
  //   2 falling edges only
  //   3 both edges
  //   pin edge detector starts low, so a pin high out of reset
  //   looks like a rising edge on the first clock
  //
  // count loading
  //   a count write while running is dropped without an error;
  //   software must halt first, write, then restart
  //   halting freezes the count, so captures while halted take the
  //   frozen value; handy for exact software tests
  //
  // events and interrupts
  //   overflow: tick while the count is all ones, count wraps to zero
  //   capture: one-cycle hit from the channel one clock after edge
  //   status bits are sticky; a status read clears them at the
  //   access edge, but an event in that very cycle is kept
  //   irq follows status and mask one clock later, as a level
  //   ovf_irq is the overflow share of irq alone
  //   irq_vector always carries the overflow vector number
  //
  // bus timing
  //   setup edge registers answer, data and error
  //   access cycle shows pready for exactly one clock
  //   writes take effect at the access edge, like the read clear
  //   no wait states, back to back transfers are fine
  //
  // limits
  //   pin inputs are taken as synchronous; an asynchronous source
  //   needs a synchroniser in front of this block
  //   one edge per channel per clock is all that can be seen;
  //   narrower pulses are lost
  //   a capture overwrites the previous value with no overrun flag

  ////////////////////////////////////////////////////////////////////////
  logic [WIDTH-1:0]              count;
  logic [3:0]                    ctrl;
  logic [2*CHANNELS-1:0]         edge_sel;
  logic [frt_pkg::EVENT_W-1:0]   status;
  logic [frt_pkg::EVENT_W-1:0]   mask;
  logic [frt_pkg::PRESC_W-1:0]   presc;
  logic                          tick;
  logic                          ovf_evt;
  logic [CHANNELS-1:0]           cap_hit;
  logic [WIDTH-1:0]              cap_val [CHANNELS];
  logic [frt_pkg::EVENT_W-1:0]   events;
  logic                          wr_en;
  logic                          rd_en;
  logic                          running;
  logic [frt_pkg::DIV_SEL_W-1:0] div_sel;
  logic [31:0]                   next_rdata;
  logic                          next_err;
  logic                          status_rd;
  logic                          sel_count;
  logic                          sel_ctrl;
  logic                          sel_edge;
  logic                          sel_mask;

  // decode of a legal capture register address
  function automatic logic is_cap(input logic [7:0] a);
    is_cap = (a >= frt_pkg::ADDR_CAP0) &&
             (a < frt_pkg::ADDR_VECTOR) && (a[1:0] == 2'h0);
  endfunction

  // capture index from address
  function automatic logic [1:0] cap_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - frt_pkg::ADDR_CAP0;
    cap_idx = d[3:2];
  endfunction

  // terminal count of the prescaler for a division selection
  function automatic logic [frt_pkg::PRESC_W-1:0] div_last(
    input logic [1:0] sel);
    unique case (sel)
      frt_pkg::DIV_1: div_last = 3'h0;
      frt_pkg::DIV_2: div_last = 3'h1;
      frt_pkg::DIV_4: div_last = 3'h3;
      frt_pkg::DIV_8: div_last = 3'h7;
    endcase
  endfunction

  assign running = ctrl[frt_pkg::CTRL_RUN_BIT];
  assign div_sel = ctrl[frt_pkg::CTRL_DIV_LSB +: frt_pkg::DIV_SEL_W];
  // access phase; zero wait states so pready answers in that same cycle
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign status_rd = rd_en && (paddr == frt_pkg::ADDR_STATUS);

  // register selects shared by the write paths
  assign sel_count = (paddr == frt_pkg::ADDR_COUNT);
  assign sel_ctrl  = (paddr == frt_pkg::ADDR_CTRL);
  assign sel_edge  = (paddr == frt_pkg::ADDR_EDGE);
  assign sel_mask  = (paddr == frt_pkg::ADDR_MASK);

  ////////////////////////////////////////////////////////////////////////
  // prescaler: divides the machine clock while running
  always_ff @(posedge clk_sys)
  begin
    if (reset || !running)
      presc <= '0;
    else if (presc >= div_last(div_sel))
      presc <= '0;
    else
      presc <= presc + 3'h1;
  end

  assign tick = running && (presc >= div_last(div_sel));
  assign ovf_evt = tick && (count == '1);

  // counter; writes land only while halted
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      count <= '0;
    else if (wr_en && sel_count && !running)
      count <= pwdata[WIDTH-1:0];
    else if (tick)
      count <= count + 16'h0001;
  end

  // control register: run bit and division select
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ctrl <= frt_pkg::CTRL_RESET;
    else if (wr_en && sel_ctrl)
      ctrl <= pwdata[3:0];
  end

  // capture edge selects
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      edge_sel <= '0;
    else if (wr_en && sel_edge)
      edge_sel <= pwdata[2*CHANNELS-1:0];
  end

  // interrupt enables, same layout as status
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      mask <= '0;
    else if (wr_en && sel_mask)
      mask <= pwdata[frt_pkg::EVENT_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // capture channels
  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_cap
    frt_capture_chan #(
      .WIDTH(WIDTH)
    ) u_chan (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .pin      (capture_pin[i]),
      .edge_sel (edge_sel[2*i +: 2]),
      .count    (count),
      .captured (cap_val[i]),
      .hit      (cap_hit[i])
    );
  end

  assign events = {cap_hit, ovf_evt};

  // sticky status; a read clears, a new event in that cycle still wins
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      status <= '0;
    else if (status_rd)
      status <= events;
    else
      status <= status | events;
  end

  ////////////////////////////////////////////////////////////////////////
  // combined interrupt straight from a flip-flop
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(status & mask);
  end

  // overflow share of the interrupt, also registered
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ovf_irq <= 1'b0;
    else
      ovf_irq <= status[frt_pkg::STAT_OVF_BIT] &
                 mask[frt_pkg::STAT_OVF_BIT];
  end

  // constant vector number carried with the overflow request
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      irq_vector <= frt_pkg::OVF_VECTOR;
    else
      irq_vector <= frt_pkg::OVF_VECTOR;
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses answer with pslverr
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (paddr == frt_pkg::ADDR_COUNT)
      next_rdata[WIDTH-1:0] = count;
    else if (paddr == frt_pkg::ADDR_CTRL)
      next_rdata[3:0] = ctrl;
    else if (paddr == frt_pkg::ADDR_EDGE)
      next_rdata[2*CHANNELS-1:0] = edge_sel;
    else if (paddr == frt_pkg::ADDR_STATUS)
      next_rdata[frt_pkg::EVENT_W-1:0] = status;
    else if (paddr == frt_pkg::ADDR_MASK)
      next_rdata[frt_pkg::EVENT_W-1:0] = mask;
    else if (is_cap(paddr))
      next_rdata[WIDTH-1:0] = cap_val[cap_idx(paddr)];
    else if (paddr == frt_pkg::ADDR_VECTOR)
      next_rdata[7:0] = frt_pkg::OVF_VECTOR;
    else
      next_err = 1'b1;
  end

  // apb answer: registered; pready rises in the setup cycle's next edge
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else if (psel && !penable)
    begin
      pready  <= 1'b1;
      pslverr <= next_err;
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
  end
endmodule

// File: verif/frt_timer_props.sv
// checker: bus timing and interrupt properties at the timer ports
`timescale 1ns/1ps
module frt_timer_props #(
  parameter int WIDTH    = 16,
  parameter int CHANNELS = 4
) (
  input wire logic                clk_sys,
  input wire logic                reset,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [CHANNELS-1:0] capture_pin,
  input wire logic                irq,
  input wire logic                ovf_irq,
  input wire logic [7:0]          irq_vector
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  // bus answer: one wait-free access, data only while ready
  a_ready_after_setup: assert property (
    psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_one_cycle: assert property (
    pready |=> !pready) else $error("ready held too long");
  a_ready_has_cause: assert property (
    pready |-> $past(psel && !penable)) else $error("ready unasked");
  a_err_with_ready: assert property (
    pslverr |-> pready) else $error("error without ready");
  a_data_idle_zero: assert property (
    !pready |-> prdata == 32'h0) else $error("read data not idle");
  a_count_width: assert property (
    pready && !pwrite && paddr == frt_pkg::ADDR_COUNT
    |-> prdata[31:16] == 16'h0) else $error("count wider than 16");
  ////////////////////////////////////////////////////////////////////////
  // interrupt side
  a_vector_fixed: assert property (
    irq_vector == frt_pkg::OVF_VECTOR) else $error("vector wrong");
  a_vector_read: assert property (
    pready && !pwrite && paddr == frt_pkg::ADDR_VECTOR
    |-> prdata == {24'h0, frt_pkg::OVF_VECTOR}) else $error("vector read");
  a_ovf_in_irq: assert property (
    ovf_irq |-> irq) else $error("overflow not on irq");
endmodule
bind frt_timer frt_timer_props #(.WIDTH(WIDTH), .CHANNELS(CHANNELS)) i_props (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
  .irq(irq), .ovf_irq(ovf_irq), .irq_vector(irq_vector));

// File: verif/frt_pin_src.sv
// pin source model: the external signals feeding the capture inputs
`timescale 1ns/1ps
module frt_pin_src (
  input  wire logic       clk_sys,
  input  wire logic [3:0] want,
  output logic      [3:0] capture_pin
);
  // levels settle just after an edge, never mid-cycle
  always_ff @(posedge clk_sys)
  begin
    capture_pin <= want;
  end
endmodule

// File: verif/frt_timer_tb.sv
// testbench: register, overflow and capture checks against a bench model
`timescale 1ns/1ps
module frt_timer_tb;
  logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr;
  logic        irq, ovf_irq, err;
  logic [7:0]  paddr, irq_vector;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  want, capture_pin;
  logic [15:0] lfsr, v1, v2;
  int          miscompares, cmp_count;
  int          cap_m[4];
  frt_timer i_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(capture_pin), .irq(irq), .ovf_irq(ovf_irq),
    .irq_vector(irq_vector));
  frt_pin_src i_src (.clk_sys(clk_sys), .want(want),
    .capture_pin(capture_pin));
  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bus cycle: request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk_sys);
    end
    if (n == 20)
      miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard, far beyond the roughly seven hundred cycles the tests need
  initial
  begin
    #500000;
    miscompares++;
    close_out();
  end
  initial
  begin
    {reset, psel, penable, pwrite, paddr, pwdata, want} = '0;
    reset = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    lfsr = 16'h9B26;
    cap_m = '{default: 0};
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, frt_pkg::ADDR_CTRL, 0);
    chk("ctrl", rd, 0);
    apb(1'b0, frt_pkg::ADDR_VECTOR, 0);
    chk("vector", rd, 19);
    apb(1'b0, 8'h28, 0);
    chk("unmapped", 32'(err), 1);
    apb(1'b1, frt_pkg::ADDR_COUNT, 32'h8000);
    apb(1'b0, frt_pkg::ADDR_COUNT, 0);
    chk("load", rd, 32'h8000);
    apb(1'b1, frt_pkg::ADDR_CTRL, 1);
    apb(1'b1, frt_pkg::ADDR_COUNT, 32'h10);
    apb(1'b1, frt_pkg::ADDR_CTRL, 0);
    apb(1'b0, frt_pkg::ADDR_COUNT, 0);
    chk("run_write", 32'(rd > 32'h8000), 1);
    $display("test registers done");
    // 51 cycles of run per ratio; start phase allows a small slack
    for (int d = 0; d < 4; d++)
    begin
      apb(1'b1, frt_pkg::ADDR_COUNT, 0);
      apb(1'b1, frt_pkg::ADDR_CTRL, 32'(1 | (d << 1)));
      repeat (48) @(posedge clk_sys);
      apb(1'b1, frt_pkg::ADDR_CTRL, 0);
      apb(1'b0, frt_pkg::ADDR_COUNT, 0);
      chk("divide", 32'(rd + 2 >= (51 >> d) && rd <= (51 >> d) + 2), 1);
    end
    $display("test prescaler done");
    apb(1'b1, frt_pkg::ADDR_MASK, 1);
    apb(1'b1, frt_pkg::ADDR_COUNT, 32'hFFF0);
    apb(1'b1, frt_pkg::ADDR_CTRL, 1);
    repeat (30) @(posedge clk_sys);
    chk("ovf_irq", 32'(ovf_irq), 1);
    chk("irq", 32'(irq), 1);
    apb(1'b1, frt_pkg::ADDR_CTRL, 0);
    apb(1'b0, frt_pkg::ADDR_COUNT, 0);
    chk("wrap", 32'(rd < 64), 1);
    apb(1'b0, frt_pkg::ADDR_STATUS, 0);
    chk("status", rd, 1);
    apb(1'b0, frt_pkg::ADDR_STATUS, 0);
    chk("cleared", rd, 0);
    repeat (3) @(posedge clk_sys);
    chk("irq_low", 32'(irq), 0);
    $display("test overflow done");
    // halted counter makes the captured count exact; every edge mode
    apb(1'b1, frt_pkg::ADDR_MASK, 32'h1E);
    for (int ch = 0; ch < 4; ch++)
      for (int m = 0; m < 4; m++)
      begin
        lfsr = lfsr_next(lfsr);
        v1 = lfsr;
        lfsr = lfsr_next(lfsr);
        v2 = lfsr;
        apb(1'b1, frt_pkg::ADDR_EDGE, 32'(m << (2 * ch)));
        apb(1'b1, frt_pkg::ADDR_COUNT, 32'(v1));
        want[ch] <= 1'b1;
        repeat (3) @(posedge clk_sys);
        apb(1'b1, frt_pkg::ADDR_COUNT, 32'(v2));
        want[ch] <= 1'b0;
        // fall lands two edges late, irq two more: wait it out fully
        repeat (5) @(posedge clk_sys);
        if (m == 1)
          cap_m[ch] = v1;
        else if (m > 1)
          cap_m[ch] = v2;
        chk("cap_irq", 32'(irq), 32'(m != 0));
        apb(1'b0, frt_pkg::ADDR_STATUS, 0);
        chk("cap_status", rd, 32'(m != 0) << (1 + ch));
        apb(1'b0, 8'(frt_pkg::ADDR_CAP0 + 4 * ch), 0);
        chk("cap_value", rd, 32'(cap_m[ch]));
      end
    $display("test capture done");
    close_out();
  end
endmodule
